// >>> rtl/amx_defines.svh
// Register offsets, field positions, reset values and timing counts
// for the converter's input selector, scan and calibration registers.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef AMX_DEFINES_SVH
`define AMX_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define AMX_OFS_SELECTOR   4'h6
`define AMX_OFS_SCAN       4'h7
`define AMX_OFS_TIMER      4'h8
`define AMX_OFS_OFFSET     4'h9
`define AMX_OFS_GAIN       4'ha

// ****************************************************************
// Reset values
// ****************************************************************
`define AMX_RST_POS_SEL    4'h0
`define AMX_RST_NEG_SEL    4'h1
`define AMX_RST_SCAN       24'h000000
`define AMX_RST_TIMER      24'h000000
`define AMX_RST_OFFSET     24'h000000
`define AMX_RST_GAIN       24'h800000

// ****************************************************************
// Scan register fields
// ****************************************************************
`define AMX_SCAN_GAP_HI    23
`define AMX_SCAN_GAP_LO    21
`define AMX_SCAN_RSVD_BIT  20
`define AMX_SCAN_EN_HI     15
`define AMX_SCAN_EN_LO     0

// ****************************************************************
// Selector source codes
// ****************************************************************
`define AMX_SRC_GROUND     4'h8
`define AMX_SRC_SUPPLY     4'h9
`define AMX_SRC_RESERVED   4'ha
`define AMX_SRC_REF_HIGH   4'hb
`define AMX_SRC_REF_LOW    4'hc
`define AMX_SRC_DIODE_P    4'hd
`define AMX_SRC_DIODE_M    4'he
`define AMX_SRC_COMMON     4'hf

// ****************************************************************
// Timing: shortest nonzero scan gap, in master-clock periods
// ****************************************************************
`define AMX_GAP_BASE_CYC   10'h008

`endif

// >>> rtl/amx_mux_decode.sv
// Decoder for one 4-bit input selector into a one-hot source route.
// Assumes the code comes from a register; outputs are combinational.
`timescale 1ns/1ps
`default_nettype none
`include "amx_defines.svh"

module amx_mux_decode (
  amx_sel_if.dec sel
);

  // Codes 0-7 channels, 8 ground, 9 supply, b-f internal sources
  always_comb begin
    sel.route = 16'h0000;
    if (sel.code != `AMX_SRC_RESERVED) begin // RULE_01 RULE_02
      sel.route[sel.code] = 1'b1;
    end
  end

  // Either diode terminal draws the fixed bias current
  assign sel.diode_bias = (sel.code == `AMX_SRC_DIODE_P) ||
                          (sel.code == `AMX_SRC_DIODE_M); // RULE_05

endmodule

`default_nettype wire

// >>> rtl/amx_pkg.sv
// Types shared by the selector and scan register logic.
// Assumes nothing beyond a SystemVerilog compiler.
package amx_pkg;

  // Scan sequencer states, one-hot
  typedef enum logic [2:0] {
    AMX_IDLE = 3'b001,
    AMX_CONV = 3'b010,
    AMX_GAP  = 3'b100
  } amx_state_t;

endpackage

// >>> rtl/amx_regs.sv
// Input selector, scan sequence, timer and calibration registers,
// with the scan sequencer that walks the enabled inputs.
// Assumes a synchronous register port from the serial command layer
// and conversion done pulses from the converter core, all on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "amx_defines.svh"

// Overview of operation
// (RULE_01) Negative selector codes 0-7 pick channels 0-7; code 8 ground.
// (RULE_02) Codes f,e,d,c,b,9: common mode, diode M/P, ref low/high, supply.
// (RULE_03) Software never writes reserved selector code 1010.
// (RULE_04) Negative selector resets to code 0001, channel 1.
// (RULE_05) Diode codes enable diode bias; temperature wants selector 0xde.
// (RULE_06) Software avoids codes of unbonded channels on smaller variants.
// (RULE_07) Gap field bits 23:21 waits 0 or 8..512 clocks between conversions.
// (RULE_08) Offset correction is a 24-bit two's-complement code, reset zero.
// (RULE_09) Gain correction is a 24-bit unsigned code, reset 800000 hex.
// (RULE_10) Positive selector is the upper nibble, same encoding, reset 0000.
// (RULE_11) Set scan enable bits include that input in the scan sequence.
// (RULE_12) Software writes reserved bit 20 as zero; bits 19:16 read zero.
module amx_regs (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [23:0] reg_wdata,
  output logic      [23:0] reg_rdata,
  output logic             reg_rvalid,
  output logic      [15:0] pos_route,
  output logic      [15:0] neg_route,
  output logic             diode_bias_en,
  output logic      [23:0] scan_timer,
  output logic      [23:0] offset_correction,
  output logic      [23:0] gain_correction,
  input  wire logic        scan_start,
  input  wire logic        conv_done,
  output logic             conv_req,
  output logic      [3:0]  scan_slot,
  output logic             scan_busy,
  output logic             scan_done
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [3:0]  pos_input_select_ff;
  logic [3:0]  neg_input_select_ff;
  logic [2:0]  scan_gap_field_ff;
  logic        scan_rsvd_ff;
  logic [15:0] scan_enables_ff;
  logic [23:0] timer_ff;
  logic [23:0] offset_ff;
  logic [23:0] gain_ff;

  // Selector byte, upper nibble positive, lower nibble negative
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos_input_select_ff <= `AMX_RST_POS_SEL; // RULE_10
      neg_input_select_ff <= `AMX_RST_NEG_SEL; // RULE_04
    end else if (reg_wr && reg_addr == `AMX_OFS_SELECTOR) begin
      pos_input_select_ff <= reg_wdata[7:4]; // RULE_10
      neg_input_select_ff <= reg_wdata[3:0];
    end
  end

  // Reset word held as a constant so its fields can be selected
  localparam logic [23:0] SCAN_RST = `AMX_RST_SCAN;

  // Scan settings; bits 19:16 are not stored at all
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scan_gap_field_ff <= SCAN_RST[`AMX_SCAN_GAP_HI:`AMX_SCAN_GAP_LO];
      scan_rsvd_ff      <= SCAN_RST[`AMX_SCAN_RSVD_BIT];
      scan_enables_ff   <= SCAN_RST[`AMX_SCAN_EN_HI:`AMX_SCAN_EN_LO];
    end else if (reg_wr && reg_addr == `AMX_OFS_SCAN) begin
      scan_gap_field_ff <= reg_wdata[`AMX_SCAN_GAP_HI:`AMX_SCAN_GAP_LO];
      scan_rsvd_ff      <= reg_wdata[`AMX_SCAN_RSVD_BIT];
      scan_enables_ff   <= reg_wdata[`AMX_SCAN_EN_HI:`AMX_SCAN_EN_LO];
    end
  end

  // Timer and calibration words
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_ff  <= `AMX_RST_TIMER;
      offset_ff <= `AMX_RST_OFFSET; // RULE_08
      gain_ff   <= `AMX_RST_GAIN;   // RULE_09
    end else if (reg_wr) begin
      if (reg_addr == `AMX_OFS_TIMER) begin
        timer_ff <= reg_wdata;
      end else if (reg_addr == `AMX_OFS_OFFSET) begin
        offset_ff <= reg_wdata; // RULE_08
      end else if (reg_addr == `AMX_OFS_GAIN) begin
        gain_ff <= reg_wdata; // RULE_09
      end
    end
  end

  assign scan_timer        = timer_ff;
  assign offset_correction = offset_ff; // Bit 23 is the sign
  assign gain_correction   = gain_ff;   // 800000 hex is unity

  // ****************************************************************
  // Register read port
  // ****************************************************************
  logic [23:0] nxt_rdata;

  // Unmapped offsets read as zero rather than holding stale data
  always_comb begin
    nxt_rdata = 24'h000000;
    if (reg_addr == `AMX_OFS_SELECTOR) begin
      nxt_rdata = {16'h0000, pos_input_select_ff, neg_input_select_ff};
    end else if (reg_addr == `AMX_OFS_SCAN) begin
      nxt_rdata = {scan_gap_field_ff, scan_rsvd_ff, 4'h0,
                   scan_enables_ff}; // RULE_12
    end else if (reg_addr == `AMX_OFS_TIMER) begin
      nxt_rdata = timer_ff;
    end else if (reg_addr == `AMX_OFS_OFFSET) begin
      nxt_rdata = offset_ff;
    end else if (reg_addr == `AMX_OFS_GAIN) begin
      nxt_rdata = gain_ff;
    end
  end

  // Read data lands one clock after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 24'h000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= nxt_rdata;
      end
    end
  end

  // ****************************************************************
  // Selector decode
  // ****************************************************************
  amx_sel_if pos_sel ();
  amx_sel_if neg_sel ();

  assign pos_sel.code = pos_input_select_ff;
  assign neg_sel.code = neg_input_select_ff;

  amx_mux_decode u_pos_dec (
    .sel (pos_sel)
  );

  amx_mux_decode u_neg_dec (
    .sel (neg_sel)
  );

  // Routes are registered so the analog switches see no decode glitches
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos_route     <= 16'h0000;
      neg_route     <= 16'h0000;
      diode_bias_en <= 1'b0;
    end else begin
      pos_route     <= pos_sel.route; // RULE_10
      neg_route     <= neg_sel.route; // RULE_01 RULE_02
      diode_bias_en <= pos_sel.diode_bias | neg_sel.diode_bias; // RULE_05
    end
  end

  // ****************************************************************
  // Scan sequencer
  // ****************************************************************
  amx_pkg::amx_state_t state_ff;
  logic [9:0]          gap_cnt_ff;
  logic [4:0]          search_from;
  logic                next_found;
  logic [3:0]          next_slot;
  logic [9:0]          gap_cycles;

  // Search restarts at 0 from idle, else just past the current slot
  assign search_from = (state_ff == amx_pkg::AMX_IDLE) ? 5'h00 :
                       {1'b0, scan_slot} + 5'h01;

  // Lowest enabled input at or above the search start
  always_comb begin
    next_found = 1'b0;
    next_slot  = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (scan_enables_ff[i] && i >= search_from) begin // RULE_11
        next_found = 1'b1;
        next_slot  = 4'(i);
      end
    end
  end

  // Gap of 8 << (code - 1) clocks; code 0 skips the gap state
  assign gap_cycles = `AMX_GAP_BASE_CYC <<
                      (scan_gap_field_ff - 3'h1); // RULE_07

  // Enables are sampled live, so a rewrite mid-scan takes effect
  // at the next slot search rather than at the next scan start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= amx_pkg::AMX_IDLE;
      gap_cnt_ff <= 10'h000;
      scan_slot  <= 4'h0;
      conv_req   <= 1'b0;
      scan_busy  <= 1'b0;
      scan_done  <= 1'b0;
    end else begin
      conv_req  <= 1'b0;
      scan_done <= 1'b0;
      case (state_ff)
        amx_pkg::AMX_IDLE: begin
          if (scan_start && next_found) begin
            scan_slot <= next_slot; // RULE_11
            conv_req  <= 1'b1;
            scan_busy <= 1'b1;
            state_ff  <= amx_pkg::AMX_CONV;
          end
        end
        amx_pkg::AMX_CONV: begin
          if (conv_done) begin
            if (!next_found) begin
              scan_busy <= 1'b0;
              scan_done <= 1'b1;
              state_ff  <= amx_pkg::AMX_IDLE;
            end else if (scan_gap_field_ff == 3'h0) begin
              scan_slot <= next_slot; // RULE_07
              conv_req  <= 1'b1;
            end else begin
              gap_cnt_ff <= gap_cycles - 10'h001; // RULE_07
              state_ff   <= amx_pkg::AMX_GAP;
            end
          end
        end
        amx_pkg::AMX_GAP: begin
          if (gap_cnt_ff != 10'h000) begin
            gap_cnt_ff <= gap_cnt_ff - 10'h001;
          end else if (next_found) begin
            scan_slot <= next_slot;
            conv_req  <= 1'b1;
            state_ff  <= amx_pkg::AMX_CONV;
          end else begin
            scan_busy <= 1'b0;
            scan_done <= 1'b1;
            state_ff  <= amx_pkg::AMX_IDLE;
          end
        end
        default: begin
          state_ff  <= amx_pkg::AMX_IDLE;
          scan_busy <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> rtl/amx_sel_if.sv
// Carrier between the register bank and one selector decoder.
// Assumes one decoder instance per interface instance.
`timescale 1ns/1ps
`default_nettype none

interface amx_sel_if;
  logic [3:0]  code;
  logic [15:0] route;
  logic        diode_bias;

  modport regs (output code, input route, input diode_bias);
  modport dec  (input code, output route, output diode_bias);
endinterface

`default_nettype wire

// >>> testbench/adc_mux_scan_calibration_regs_test.sv
// Self-checking bench for the register bank and scan sequencer.
// Assumes amx_regs and its defines header; bench drives every port.
`timescale 1ns/1ps
`default_nettype none
`include "amx_defines.svh"

module adc_mux_scan_calibration_regs_test;
  logic        mclk, rst_n, reg_wr, reg_rd, scan_start, conv_done;
  logic [3:0]  reg_addr, scan_slot;
  logic [23:0] reg_wdata, reg_rdata, scan_timer, offs, gain;
  logic [15:0] pos_route, neg_route;
  logic        reg_rvalid, diode_bias_en, conv_req, scan_busy, scan_done;
  int          n_errors, samples_checked, n, need;

  amx_regs dut (
    .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pos_route(pos_route), .neg_route(neg_route),
    .diode_bias_en(diode_bias_en), .scan_timer(scan_timer),
    .offset_correction(offs), .gain_correction(gain),
    .scan_start(scan_start), .conv_done(conv_done), .conv_req(conv_req),
    .scan_slot(scan_slot), .scan_busy(scan_busy), .scan_done(scan_done)
  );

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    reg_addr = a;
    reg_wdata = d;
    pulse(reg_wr);
  endtask
  // Read answer comes exactly one cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [23:0] exp);
    reg_addr = a;
    pulse(reg_rd);
    cmp({23'h0, reg_rvalid}, 24'h000001);
    cmp(reg_rdata, exp);
  endtask
  // Bounded wait, counted from the cycle the done strobe was raised;
  // a hang counts as a mismatch and ends the run
  task automatic wait_ev(input logic want_done);
    n = 1;
    while ((want_done ? scan_done : conv_req) !== 1'b1 && n < 1100) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 1100) begin
      n_errors++;
      final_report();
    end
  endtask
  function automatic logic [23:0] rte(input logic [3:0] c);
    return (c == 4'ha) ? 24'h0 : 24'h1 << c;
  endfunction

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    {rst_n, reg_wr, reg_rd, scan_start, conv_done} = 5'h00;
    reg_addr = 4'h0;
    reg_wdata = 24'h0;
    {n_errors, samples_checked} = 0;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    cmp({8'h0, pos_route}, 24'h000001);
    cmp({8'h0, neg_route}, 24'h000002);
    cmp(gain, 24'h800000);
    rd(`AMX_OFS_SELECTOR, 24'h000001);
    rd(`AMX_OFS_SCAN, 24'h000000);
    rd(`AMX_OFS_OFFSET, 24'h000000);
    rd(`AMX_OFS_GAIN, 24'h800000);
    $display("reset values done");
    // Both selectors walk every code except 5 and reserved a, upper and lower nibble differ
    // Full eight-channel part, so every channel code is bonded
    for (int c = 0; c < 16; c++) begin
      if (c == 5 || c == 10) continue;
      wr(`AMX_OFS_SELECTOR, {16'h0, c[3:0], ~c[3:0]});
      @(negedge mclk);
      cmp({8'h0, pos_route}, rte(c[3:0]));
      cmp({8'h0, neg_route}, rte(~c[3:0]));
      cmp(diode_bias_en, c inside {1, 2, 13, 14});
    end
    wr(`AMX_OFS_SELECTOR, 24'h0000de);
    rd(`AMX_OFS_SELECTOR, 24'h0000de);
    cmp(diode_bias_en, 1'b1);
    $display("selector codes done");
    wr(`AMX_OFS_SCAN, 24'hefffff);
    rd(`AMX_OFS_SCAN, 24'he0ffff);
    wr(`AMX_OFS_TIMER, 24'hc3a5f0);
    cmp(scan_timer, 24'hc3a5f0);
    rd(`AMX_OFS_TIMER, 24'hc3a5f0);
    wr(`AMX_OFS_OFFSET, 24'h800001);
    cmp(offs, 24'h800001);
    wr(`AMX_OFS_GAIN, 24'h123456);
    wr(4'h3, 24'hffffff);
    rd(`AMX_OFS_GAIN, 24'h123456);
    cmp(gain, 24'h123456);
    rd(4'hf, 24'h000000);
    $display("register access done");
    wr(`AMX_OFS_SCAN, 24'h000000);
    pulse(scan_start);
    cmp(conv_req, 1'b0);
    // Slots 0 and 15 under every gap code
    for (int g = 0; g < 8; g++) begin
      need = (g == 0) ? 0 : 8 << (g - 1);
      wr(`AMX_OFS_SCAN, {g[2:0], 5'h00, 16'h8001});
      pulse(scan_start);
      cmp({conv_req, scan_busy, scan_slot}, 6'h30);
      pulse(conv_done);
      wait_ev(1'b0);
      cmp(24'(n), 24'(need + 1));
      cmp(scan_slot, 4'hf);
      pulse(conv_done);
      wait_ev(1'b1);
      cmp(24'(n), 24'h000001);
      cmp({scan_busy, scan_done}, 2'b01);
    end
    $display("scan gaps done");
    final_report();
  end
endmodule

`default_nettype wire

// >>> testbench/amx_regs_props.sv
// Concurrent checks on the register bank and scan sequencer ports.
// Assumes it is bound to amx_regs, one clock domain on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "amx_defines.svh"

module amx_regs_props (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [3:0]  reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic [15:0] pos_route,
  input wire logic [15:0] neg_route,
  input wire logic        diode_bias_en,
  input wire logic [23:0] offset_correction,
  input wire logic [23:0] gain_correction,
  input wire logic        scan_start,
  input wire logic        conv_done,
  input wire logic        conv_req,
  input wire logic [3:0]  scan_slot,
  input wire logic        scan_busy,
  input wire logic        scan_done
);
  // ************************************************************
  // Shadow state and assertions
  // ************************************************************
  logic [15:0] en_ff;
  logic [2:0]  gap_ff;
  logic [9:0]  cnt_ff;
  logic [9:0]  need;
  logic        sel_wr;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  function automatic logic [15:0] rte(input logic [3:0] c);
    return (c == `AMX_SRC_RESERVED) ? 16'h0000 : 16'h0001 << c;
  endfunction

  // Shadow of the scan word, so gap and enables are known here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_ff <= 16'h0000;
      gap_ff <= 3'h0;
    end else if (reg_wr && reg_addr == `AMX_OFS_SCAN) begin
      en_ff <= reg_wdata[15:0];
      gap_ff <= reg_wdata[23:21];
    end
  end
  // Cycles since the last finished conversion, saturating
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      cnt_ff <= 10'h000;
    else if (conv_done)
      cnt_ff <= 10'h000;
    else if (cnt_ff != 10'h3ff)
      cnt_ff <= cnt_ff + 10'h001;
  end
  assign need = (gap_ff == 3'h0) ? 10'h000 : 10'h008 << (gap_ff - 3'h1);
  assign sel_wr = reg_wr && reg_addr == `AMX_OFS_SELECTOR;

  a_offset_write: assert property (
    reg_wr && reg_addr == `AMX_OFS_OFFSET
    |=> offset_correction == $past(reg_wdata)) else $error("offset lost");
  a_gain_write: assert property (
    reg_wr && reg_addr == `AMX_OFS_GAIN
    |=> gain_correction == $past(reg_wdata)) else $error("gain lost");
  a_gain_read: assert property (
    reg_rd && reg_addr == `AMX_OFS_GAIN
    |=> reg_rdata == $past(gain_correction)) else $error("gain read bad");
  a_neg_route: assert property (
    sel_wr ##1 !sel_wr |=> neg_route == rte($past(reg_wdata[3:0], 2)))
    else $error("negative route bad");
  a_pos_route: assert property (
    sel_wr ##1 !sel_wr |=> pos_route == rte($past(reg_wdata[7:4], 2)))
    else $error("positive route bad");
  a_diode_bias: assert property (
    diode_bias_en == (|{pos_route[14:13], neg_route[14:13]}))
    else $error("diode bias bad");
  a_gap_exact: assert property (
    conv_req && $past(scan_busy) |-> cnt_ff == need)
    else $error("scan gap wrong");
  a_slot_enabled: assert property (
    conv_req |-> en_ff[scan_slot]) else $error("slot not enabled");
  a_start_answer: assert property (
    scan_start && !scan_busy && !conv_req && en_ff != 16'h0000
    |=> conv_req && scan_busy) else $error("scan did not start");
  a_done_pulse: assert property (
    scan_done |-> !scan_busy ##1 !scan_done) else $error("done bad");

  c_long_gap: cover property (conv_req && $past(scan_busy) && gap_ff == 3'h7);
  c_done: cover property (scan_done);
  c_bias: cover property (diode_bias_en);
endmodule

bind amx_regs amx_regs_props u_props (
  .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .pos_route(pos_route), .neg_route(neg_route),
  .diode_bias_en(diode_bias_en), .offset_correction(offset_correction),
  .gain_correction(gain_correction), .scan_start(scan_start),
  .conv_done(conv_done), .conv_req(conv_req), .scan_slot(scan_slot),
  .scan_busy(scan_busy), .scan_done(scan_done)
);

`default_nettype wire
